// *** design/sltpg_cfg.svh ***
// Constants of the serial link test pattern generator
`ifndef SLTPG_CFG_SVH
`define SLTPG_CFG_SVH

`define SLTPG_GROUP_LANES 4
`define SLTPG_LANES 8
`define SLTPG_OCTET_W 8
`define SLTPG_OCTET_ZERO 8'h00
`define SLTPG_OCTET_ONES 8'hff
`define SLTPG_D215 8'hb5
`define SLTPG_K285 8'hbc
`define SLTPG_K280 8'h1c
`define SLTPG_K283 8'h7c
`define SLTPG_K284 8'h9c
`define SLTPG_ILA_FIRST 4'h0
`define SLTPG_ILA_SECOND 4'h1
`define SLTPG_ILA_LAST 4'hf
`define SLTPG_RPAT_FIRST 4'h0
`define SLTPG_RPAT_LAST 4'hb
`define SLTPG_RPAT0 8'hbe
`define SLTPG_RPAT1 8'hd7
`define SLTPG_RPAT2 8'h23
`define SLTPG_RPAT3 8'h47
`define SLTPG_RPAT4 8'h6b
`define SLTPG_RPAT5 8'h8f
`define SLTPG_RPAT6 8'hb3
`define SLTPG_RPAT7 8'h14
`define SLTPG_RPAT8 8'h5e
`define SLTPG_RPAT9 8'hfb
`define SLTPG_RPAT10 8'h35
`define SLTPG_RPAT11 8'h59
`define SLTPG_LANES_ONE 4'h1
`define SLTPG_LANES_TWO 4'h3
`define SLTPG_LANES_FOUR 4'hf

`endif

// *** design/sltpg_pkg.sv ***
// Types of the serial link test pattern generator
package sltpg_pkg;

  typedef enum logic [2:0] {
    SLTPG_TM_NORMAL = 3'h0,
    SLTPG_TM_TRANSPORT = 3'h1,
    SLTPG_TM_D215 = 3'h2,
    SLTPG_TM_K285 = 3'h3,
    SLTPG_TM_ILA_REPEAT = 3'h4,
    SLTPG_TM_RPAT = 3'h5
  } sltpg_mode_t;

  typedef enum logic [1:0] {
    SLTPG_LM_ONE = 2'h0,
    SLTPG_LM_TWO = 2'h1,
    SLTPG_LM_FOUR = 2'h2
  } sltpg_lanes_t;

  typedef enum logic [1:0] {
    SLTPG_ST_OFF = 2'h0,
    SLTPG_ST_CGS = 2'h1,
    SLTPG_ST_ILA = 2'h2,
    SLTPG_ST_DATA = 2'h3
  } sltpg_state_t;

  typedef struct packed {
    sltpg_state_t state;
    logic frameOdd;
    logic [3:0] ilaCnt;
    logic [3:0] rpatIdx;
    logic [63:0] octets;
    logic [7:0] charK;
    logic [7:0] laneEn;
    logic tpOut;
    logic tpOdd;
  } sltpg_regs_t;

endpackage : sltpg_pkg

// *** design/serial_link_test_pattern_gen.sv ***
// Transmit-side test pattern generator with a minimal link layer sequencer
//
// Summary of operation
// - Transport test pattern repeats over two frames
// - Frame 0 lane index, frame 1 complement
// - Only enabled lanes, the lowest one, two or four of each group of four per lane mode, carry the pattern
// - Transport pattern independent of link encoding
// - D21.5 mode sends continuous D21.5 stream
// - K28.5 mode sends commas, 8b/10b only
// - Repeated ILA mode never enters data phase with 8b/10b; with 64b/66b it goes straight to data
// - Sync request restarts code group synchronization, 8b/10b only
// - RPAT mode sends 12-octet pattern, 8b/10b only
// - RPAT octet order fixed, then wraps
// - Lane count follows lane mode, any test
`timescale 1ns/100ps
`include "sltpg_cfg.svh"

module serial_link_test_pattern_gen (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic linkEnable,
  input wire logic encoding64b,
  input wire logic [2:0] test_pattern_select,
  input wire logic [1:0] lane_mode_select,
  input wire logic syncRequestN,
  input wire logic [63:0] sampleData,
  output logic [63:0] laneOctet,
  output logic [7:0] laneCharK,
  output logic [7:0] laneEnable
);

  ////////////////////////////////////////////////////////////////////////////
  sltpg_pkg::sltpg_regs_t s_q;
  sltpg_pkg::sltpg_regs_t s_d;
  sltpg_pkg::sltpg_mode_t mode;
  logic [3:0] groupEn;
  logic is8b10b;
  logic directTest;

  assign mode = sltpg_pkg::sltpg_mode_t'(test_pattern_select);
  assign is8b10b = ~encoding64b;

  function automatic logic [7:0] rpatOctet(input logic [3:0] idx);
    logic [7:0] v;
    v = `SLTPG_RPAT0;
    case (idx)
      4'h1: v = `SLTPG_RPAT1;
      4'h2: v = `SLTPG_RPAT2;
      4'h3: v = `SLTPG_RPAT3;
      4'h4: v = `SLTPG_RPAT4;
      4'h5: v = `SLTPG_RPAT5;
      4'h6: v = `SLTPG_RPAT6;
      4'h7: v = `SLTPG_RPAT7;
      4'h8: v = `SLTPG_RPAT8;
      4'h9: v = `SLTPG_RPAT9;
      4'ha: v = `SLTPG_RPAT10;
      4'hb: v = `SLTPG_RPAT11;
      default: v = `SLTPG_RPAT0;
    endcase
    return v;
  endfunction : rpatOctet

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    groupEn = `SLTPG_LANES_ONE;
    case (sltpg_pkg::sltpg_lanes_t'(lane_mode_select))
      sltpg_pkg::SLTPG_LM_TWO: groupEn = `SLTPG_LANES_TWO;
      sltpg_pkg::SLTPG_LM_FOUR: groupEn = `SLTPG_LANES_FOUR;
      default: groupEn = `SLTPG_LANES_ONE;
    endcase
  end

  // Character-level streams bypass the sync handshake entirely
  assign directTest = linkEnable && ((mode == sltpg_pkg::SLTPG_TM_D215) ||
    (is8b10b && (mode == sltpg_pkg::SLTPG_TM_K285 || mode == sltpg_pkg::SLTPG_TM_RPAT)));

  always_comb begin
    logic [7:0] oct;
    logic k;
    logic [1:0] laneIdx;
    s_d = s_q;
    oct = `SLTPG_OCTET_ZERO;
    k = 1'b0;
    laneIdx = 2'h0;
    s_d.laneEn = {groupEn, groupEn};
    s_d.tpOut = 1'b0;
    s_d.tpOdd = s_q.frameOdd;
    // Outputs are built from the state held this cycle and registered, so they appear one cycle later
    for (int i = 0; i < `SLTPG_LANES; i++) begin
      laneIdx = 2'(i % `SLTPG_GROUP_LANES);
      oct = `SLTPG_OCTET_ZERO;
      k = 1'b0;
      if (directTest) begin
        case (mode)
          sltpg_pkg::SLTPG_TM_D215: oct = `SLTPG_D215;
          sltpg_pkg::SLTPG_TM_K285: begin
            oct = `SLTPG_K285;
            k = 1'b1;
          end
          default: oct = rpatOctet(s_q.rpatIdx);
        endcase
      end else begin
        case (s_q.state)
          sltpg_pkg::SLTPG_ST_CGS: begin
            oct = `SLTPG_K285;
            k = 1'b1;
          end
          sltpg_pkg::SLTPG_ST_ILA: begin
            k = 1'b1;
            if (s_q.ilaCnt == `SLTPG_ILA_FIRST) begin
              oct = `SLTPG_K280;
            end else if (s_q.ilaCnt == `SLTPG_ILA_SECOND) begin
              oct = `SLTPG_K284;
            end else if (s_q.ilaCnt == `SLTPG_ILA_LAST) begin
              oct = `SLTPG_K283;
            end else begin
              oct = {4'h0, s_q.ilaCnt};
              k = 1'b0;
            end
          end
          sltpg_pkg::SLTPG_ST_DATA: begin
            // Same source for both encodings; link layer framing follows
            if (mode == sltpg_pkg::SLTPG_TM_TRANSPORT) begin
              oct = {6'h00, laneIdx} ^
                (s_q.frameOdd ? `SLTPG_OCTET_ONES : `SLTPG_OCTET_ZERO);
            end else begin
              oct = sampleData[i*`SLTPG_OCTET_W +: `SLTPG_OCTET_W];
            end
          end
          default: oct = `SLTPG_OCTET_ZERO;
        endcase
      end
      if (!s_d.laneEn[i]) begin
        oct = `SLTPG_OCTET_ZERO;
        k = 1'b0;
      end
      s_d.octets[i*`SLTPG_OCTET_W +: `SLTPG_OCTET_W] = oct;
      s_d.charK[i] = k;
    end
    s_d.tpOut = !directTest && (s_q.state == sltpg_pkg::SLTPG_ST_DATA) &&
      (mode == sltpg_pkg::SLTPG_TM_TRANSPORT);

    // Frame phase and pattern pointers
    s_d.frameOdd = (s_q.state == sltpg_pkg::SLTPG_ST_DATA) ? ~s_q.frameOdd : 1'b0;
    if (directTest && mode == sltpg_pkg::SLTPG_TM_RPAT) begin
      s_d.rpatIdx = (s_q.rpatIdx == `SLTPG_RPAT_LAST) ? `SLTPG_RPAT_FIRST :
        s_q.rpatIdx + 4'h1;
    end else begin
      s_d.rpatIdx = `SLTPG_RPAT_FIRST;
    end

    // Link sequencer
    if (!linkEnable) begin
      s_d.state = sltpg_pkg::SLTPG_ST_OFF;
    end else begin
      case (s_q.state)
        sltpg_pkg::SLTPG_ST_OFF: begin
          s_d.state = is8b10b ? sltpg_pkg::SLTPG_ST_CGS : sltpg_pkg::SLTPG_ST_DATA;
        end
        sltpg_pkg::SLTPG_ST_CGS: begin
          if (syncRequestN) begin
            s_d.state = sltpg_pkg::SLTPG_ST_ILA;
            s_d.ilaCnt = `SLTPG_ILA_FIRST;
          end
        end
        sltpg_pkg::SLTPG_ST_ILA: begin
          s_d.ilaCnt = s_q.ilaCnt + 4'h1;
          if (s_q.ilaCnt == `SLTPG_ILA_LAST &&
              mode != sltpg_pkg::SLTPG_TM_ILA_REPEAT) begin
            s_d.state = sltpg_pkg::SLTPG_ST_DATA;
          end
        end
        default: s_d.state = s_q.state;
      endcase
      // A sync request in any live 8b/10b phase restarts alignment
      if (is8b10b && !syncRequestN && s_q.state != sltpg_pkg::SLTPG_ST_OFF) begin
        s_d.state = sltpg_pkg::SLTPG_ST_CGS;
        s_d.ilaCnt = `SLTPG_ILA_FIRST;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign laneOctet = s_q.octets;
  assign laneCharK = s_q.charK;
  assign laneEnable = s_q.laneEn;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic rpatOn;
  assign rpatOn = linkEnable && is8b10b && mode == sltpg_pkg::SLTPG_TM_RPAT;

  a_tp_period: assert property (s_q.tpOut && $past(s_q.tpOut) |->
    s_q.tpOdd != $past(s_q.tpOdd)) else $error("transport frame phase stuck");
  a_tp_values: assert property (s_q.tpOut && laneEnable[1] |->
    laneOctet[15:8] == (s_q.tpOdd ? 8'hfe : 8'h01) && laneOctet[47:40] == laneOctet[15:8])
    else $error("transport octet wrong on lane 1");
  a_lane_off: assert property (!laneEnable[7] |->
    laneOctet[63:56] == 8'h00 && !laneCharK[7]) else $error("disabled lane active");
  a_tp_enc64: assert property (s_q.tpOut && $past(encoding64b) |->
    laneOctet[7:0] == (s_q.tpOdd ? 8'hff : 8'h00)) else $error("transport differs in 64b");
  a_d215_stream: assert property (linkEnable && mode == sltpg_pkg::SLTPG_TM_D215 |=>
    laneOctet[7:0] == 8'hb5 && !laneCharK[0]) else $error("D21.5 stream broken");
  a_k285_stream: assert property (linkEnable && is8b10b &&
    mode == sltpg_pkg::SLTPG_TM_K285 |=> laneOctet[7:0] == 8'hbc && laneCharK[0])
    else $error("K28.5 stream broken");
  a_ila_no_data: assert property (linkEnable && is8b10b &&
    mode == sltpg_pkg::SLTPG_TM_ILA_REPEAT && s_q.state != sltpg_pkg::SLTPG_ST_DATA |=>
    s_q.state != sltpg_pkg::SLTPG_ST_DATA) else $error("data phase in repeated ILA");
  // Direct character modes ignore the request, so they are left out here
  a_sync_restart: assert property (linkEnable && is8b10b && !syncRequestN && !directTest &&
    s_q.state != sltpg_pkg::SLTPG_ST_OFF |=> s_q.state == sltpg_pkg::SLTPG_ST_CGS ##1
    laneOctet[7:0] == 8'hbc) else $error("sync request ignored");
  a_rpat_wrap: assert property (rpatOn && $past(rpatOn) && laneOctet[7:0] == 8'h59 |=>
    laneOctet[7:0] == 8'hbe ##1 laneOctet[7:0] == 8'hd7) else $error("RPAT order wrong");
  a_lane_count: assert property (lane_mode_select == 2'h1 |=>
    laneEnable == 8'h33) else $error("lane count wrong");

  c_tp_run: cover property (s_q.tpOut [*4]);
  c_ila_repeat: cover property (s_q.state == sltpg_pkg::SLTPG_ST_ILA &&
    s_q.ilaCnt == 4'hf && mode == sltpg_pkg::SLTPG_TM_ILA_REPEAT ##1
    s_q.state == sltpg_pkg::SLTPG_ST_ILA);
  c_rpat_wrap: cover property (rpatOn && laneOctet[7:0] == 8'h59 ##1 laneOctet[7:0] == 8'hbe);
  c_sync_in_data: cover property (s_q.state == sltpg_pkg::SLTPG_ST_DATA && !syncRequestN);

endmodule : serial_link_test_pattern_gen

// *** testbench/sltpg_rx_model.sv ***
// Receiver-side model that issues synchronization requests
`timescale 1ns/100ps

module sltpg_rx_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] rxOctet,
  input wire logic rxCharK,
  input wire logic resync,
  output logic syncRequestN
);
  logic [2:0] commaCnt_q;

  // Lock needs four commas in a row, so a lone comma never releases the request
  always_ff @(posedge ref_clk) begin
    if (rst || resync) begin
      commaCnt_q <= 3'h0;
      syncRequestN <= 1'b0;
    end else if (rxCharK && rxOctet == 8'hbc) begin
      if (commaCnt_q == 3'h3) syncRequestN <= 1'b1;
      else commaCnt_q <= commaCnt_q + 3'h1;
    end else if (!syncRequestN) begin
      commaCnt_q <= 3'h0;
    end
  end
endmodule : sltpg_rx_model

// *** testbench/serial_link_test_pattern_gen_tb_top.sv ***
// Self-checking testbench of the serial link test pattern generator
`timescale 1ns/100ps
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH %0t got %h exp %h", $time, (a), (b)); end end

module serial_link_test_pattern_gen_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic linkEnable = 1'b0;
  logic encoding64b = 1'b0;
  logic [2:0] testSel = 3'h0;
  logic [1:0] laneSel = 2'h0;
  logic [63:0] sampleData = 64'h8877_6655_4433_2211;
  logic resync = 1'b0;
  logic syncRequestN;
  logic [63:0] laneOctet;
  logic [7:0] laneCharK;
  logic [7:0] laneEnable;
  int miscompares = 0;
  int checksDone = 0;
  logic [7:0] rpat [12] = '{8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f,
                            8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59};

  serial_link_test_pattern_gen serial_link_test_pattern_gen_i (
    .ref_clk(ref_clk), .rst(rst), .linkEnable(linkEnable), .encoding64b(encoding64b),
    .test_pattern_select(testSel), .lane_mode_select(laneSel),
    .syncRequestN(syncRequestN), .sampleData(sampleData), .laneOctet(laneOctet),
    .laneCharK(laneCharK), .laneEnable(laneEnable));

  sltpg_rx_model sltpg_rx_model_i (
    .ref_clk(ref_clk), .rst(rst), .rxOctet(laneOctet[7:0]), .rxCharK(laneCharK[0]),
    .resync(resync), .syncRequestN(syncRequestN));

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (miscompares == 0 && checksDone > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task automatic wait_for(input logic [63:0] o, input logic [7:0] k);
    int n = 0;
    while (n < 80 && !(laneOctet === o && laneCharK === k)) begin
      @(negedge ref_clk);
      n++;
    end
    if (!(laneOctet === o && laneCharK === k)) begin
      miscompares++;
      $display("MISMATCH %0t timeout", $time);
      end_sim();
    end
  endtask : wait_for

  // Mode changes only while the link is down
  task automatic start(input logic [2:0] m, input logic e, input logic [1:0] l);
    @(posedge ref_clk) linkEnable <= 1'b0;
    repeat (2) @(posedge ref_clk);
    testSel <= m;
    encoding64b <= e;
    laneSel <= l;
    @(posedge ref_clk) linkEnable <= 1'b1;
    @(negedge ref_clk);
  endtask : start

  task automatic transport(input logic e, input logic [1:0] l, input int n);
    logic [63:0] f0 = '0;
    logic [63:0] f1 = '0;
    for (int i = 0; i < n; i++) begin
      f0[8*i+:8] = 8'(i);
      f0[32+8*i+:8] = 8'(i);
      f1[8*i+:8] = ~8'(i);
      f1[32+8*i+:8] = ~8'(i);
    end
    start(sltpg_pkg::SLTPG_TM_TRANSPORT, e, l);
    wait_for(f1, 8'h00);
    for (int j = 0; j < 6; j++) begin
      `CHK(laneOctet, j[0] ? f0 : f1)
      `CHK(laneEnable, {2{4'((1 << n) - 1)}})
      @(negedge ref_clk);
    end
  endtask : transport

  task automatic chars(input logic [2:0] m, input logic e, input logic [63:0] o,
                       input logic [7:0] k);
    start(m, e, sltpg_pkg::SLTPG_LM_FOUR);
    wait_for(o, k);
    repeat (4) begin
      @(negedge ref_clk);
      `CHK({laneCharK, laneOctet}, {k, o})
    end
  endtask : chars

  task automatic rpat_run;
    start(sltpg_pkg::SLTPG_TM_RPAT, 1'b0, sltpg_pkg::SLTPG_LM_FOUR);
    wait_for({8{8'hbe}}, 8'h00);
    for (int j = 0; j < 26; j++) begin
      `CHK(laneOctet, {8{rpat[j % 12]}})
      @(negedge ref_clk);
    end
  endtask : rpat_run

  function automatic logic [63:0] one(input logic [7:0] o);
    return {24'h0, o, 24'h0, o};
  endfunction : one

  task automatic ila_run;
    logic [7:0] o;
    logic [7:0] k;
    start(sltpg_pkg::SLTPG_TM_ILA_REPEAT, 1'b0, sltpg_pkg::SLTPG_LM_ONE);
    repeat (2) begin
      wait_for(one(8'h1c), 8'h11);
      for (int j = 0; j < 40; j++) begin
        o = j % 16 == 0 ? 8'h1c : j % 16 == 1 ? 8'h9c : j % 16 == 15 ? 8'h7c : 8'(j % 16);
        k = (j % 16 < 2 || j % 16 == 15) ? 8'h11 : 8'h00;
        `CHK({laneCharK, laneOctet}, {k, one(o)})
        @(negedge ref_clk);
      end
      @(posedge ref_clk) resync <= 1'b1;
      @(posedge ref_clk) resync <= 1'b0;
      wait_for(one(8'hbc), 8'h11);
    end
  endtask : ila_run

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    transport(1'b1, sltpg_pkg::SLTPG_LM_ONE, 1);
    transport(1'b1, sltpg_pkg::SLTPG_LM_FOUR, 4);
    transport(1'b0, sltpg_pkg::SLTPG_LM_TWO, 2);
    chars(sltpg_pkg::SLTPG_TM_D215, 1'b0, {8{8'hb5}}, 8'h00);
    chars(sltpg_pkg::SLTPG_TM_D215, 1'b1, {8{8'hb5}}, 8'h00);
    chars(sltpg_pkg::SLTPG_TM_K285, 1'b0, {8{8'hbc}}, 8'hff);
    chars(sltpg_pkg::SLTPG_TM_K285, 1'b1, sampleData, 8'h00);
    rpat_run();
    ila_run();
    end_sim();
  end
endmodule : serial_link_test_pattern_gen_tb_top
